/* hw/scrb_map.svh */
`ifndef SCRB_MAP_SVH
`define SCRB_MAP_SVH
// Control register numbers
`define SCRB_REG_BUS_SETUP    5'h02
`define SCRB_REG_PTE_PTR      5'h04
`define SCRB_REG_FAULT_ADDR   5'h08
`define SCRB_REG_CYCLE        5'h09
`define SCRB_REG_REGION_WIDTH 5'h0A
`define SCRB_REG_MATCH        5'h0B
`define SCRB_REG_MODE         5'h0C
`define SCRB_REG_REASON       5'h0D
`define SCRB_REG_EXC_PC       5'h0E
`define SCRB_REG_IDENT        5'h0F
`define SCRB_REG_CPU_SETUP    5'h10
`define SCRB_REG_INSTR_WATCH_ADDRESS       5'h12
`define SCRB_REG_DATA_WATCH_ADDRESS       5'h13
`define SCRB_REG_PTE_WIDE     5'h14
`define SCRB_REG_IMPR_PC      5'h16
`define SCRB_REG_DBG_PC       5'h17
`define SCRB_REG_DBG_CTRL     5'h18
`define SCRB_REG_ECC          5'h1A
`define SCRB_REG_CACHE_ERR    5'h1B
`define SCRB_REG_TAG_LOW      5'h1C
`define SCRB_REG_ERR_PC       5'h1E
// Identity layout
`define SCRB_IDENT_IMP_LSB    8
`define SCRB_IDENT_REV_LSB    0
// Arbitrary neutral identity values
`define SCRB_IMP_CODE         8'h5A
`define SCRB_REV_CODE         8'h01
// Cycle tally width and reset values
`define SCRB_TALLY_W          24
`define SCRB_ZERO32           32'h0000_0000
`define SCRB_ONE24            24'h00_0001
// Value returned for unimplemented numbers
`define SCRB_UNMAPPED_VAL     32'h0000_0000
`endif

/* hw/scrb_pkg.sv */
package scrb_pkg;
   typedef logic [4:0]  scrb_regnum_t;
   typedef logic [31:0] scrb_word_t;
endpackage

/* hw/scrb_tally.sv */
`timescale 1ns/1ps
`include "scrb_map.svh"
// Cycle tally with match value; wraps and pulses on match
module scrb_tally
   import scrb_pkg::*;
#(
   parameter int W = `SCRB_TALLY_W
)(
   input  wire logic         i_clk,
   input  wire logic         i_sys_rst,
   input  wire logic         i_tally_we,
   input  wire logic         i_match_we,
   input  wire logic [W-1:0] i_wdata,
   output logic      [W-1:0] o_tally,
   output logic      [W-1:0] o_match,
   output logic              o_hit
);
   logic [W-1:0] nxt_tally;
   logic         hit_now;

   // Match wraps the tally to zero
   assign hit_now   = (o_tally == o_match);
   assign nxt_tally = i_tally_we ? i_wdata :
                      hit_now ? '0 : o_tally + 1'b1;

   // Write wins over counting so software sees its value
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_tally <= '0;
         o_match <= '1;
         o_hit   <= 1'b0;
      end else begin
         o_tally <= nxt_tally;
         o_match <= i_match_we ? i_wdata : o_match;
         o_hit   <= hit_now && !i_tally_we;
      end
   end

   a_tally_wrap: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (hit_now && !i_tally_we) |=> (o_tally == '0) && o_hit)
      else $error("tally did not wrap on match");
   a_tally_step: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (!hit_now && !i_tally_we) |=> o_tally == $past(o_tally) + 1'b1)
      else $error("tally did not step");
   c_tally_hit: cover property (@(posedge i_clk) o_hit);
endmodule

/* hw/scrb_top.sv */
`timescale 1ns/1ps
`include "scrb_map.svh"
module scrb_top
   import scrb_pkg::*;
#(
   parameter logic [7:0] IMP_CODE = `SCRB_IMP_CODE, // Arbitrary value
   parameter logic [7:0] REV_CODE = `SCRB_REV_CODE  // Arbitrary value
)(
   input  wire logic         i_clk,
   input  wire logic         i_sys_rst,
   input  wire logic         i_mt_valid,
   input  wire logic         i_mf_valid,
   input  wire scrb_regnum_t i_regnum,
   input  wire scrb_word_t   i_wdata,
   input  wire logic         i_fault_valid,
   input  wire scrb_word_t   i_fault_addr,
   input  wire logic         i_ifetch_valid,
   input  wire scrb_word_t   i_ifetch_addr,
   input  wire logic         i_daccess_valid,
   input  wire scrb_word_t   i_daccess_addr,
   input  wire logic         i_cache_err_valid,
   input  wire scrb_word_t   i_cache_err_info,
   output scrb_word_t        o_rdata,
   output logic              o_rvalid,
   output logic              o_timer_hit,
   output logic              o_watch_exc,
   output scrb_word_t        o_mode_flags,
   output scrb_word_t        o_bus_signal_setup,
   output scrb_word_t        o_region_width_flags,
   output scrb_word_t        o_cpu_setup
);
   // Word registers, writable, hardware-loaded or constant, indexed by register number
   scrb_word_t   regs_ff [0:31];
   scrb_word_t   rd_mux;
   scrb_word_t   ident_word;
   logic [`SCRB_TALLY_W-1:0] tally_val;
   logic [`SCRB_TALLY_W-1:0] match_val;
   logic         tally_hit;
   logic         tally_we;
   logic         match_we;
   logic         instr_watch_address_hit;
   logic         data_watch_address_hit;

   // Registers that hold software state and accept writes
   function automatic logic is_rw(input scrb_regnum_t n);
      is_rw = (n == `SCRB_REG_BUS_SETUP) || (n == `SCRB_REG_PTE_PTR) ||
              (n == `SCRB_REG_REGION_WIDTH) || (n == `SCRB_REG_MODE) ||
              (n == `SCRB_REG_REASON) || (n == `SCRB_REG_EXC_PC) ||
              (n == `SCRB_REG_CPU_SETUP) || (n == `SCRB_REG_INSTR_WATCH_ADDRESS) ||
              (n == `SCRB_REG_DATA_WATCH_ADDRESS) || (n == `SCRB_REG_PTE_WIDE) ||
              (n == `SCRB_REG_IMPR_PC) || (n == `SCRB_REG_DBG_PC) ||
              (n == `SCRB_REG_DBG_CTRL) || (n == `SCRB_REG_ECC) ||
              (n == `SCRB_REG_TAG_LOW) || (n == `SCRB_REG_ERR_PC);
   endfunction

   // Hardware-loaded words and the constant identity: read-only to moves
   function automatic logic is_ro(input scrb_regnum_t n);
      is_ro = (n == `SCRB_REG_FAULT_ADDR) || (n == `SCRB_REG_IDENT) ||
              (n == `SCRB_REG_CACHE_ERR);
   endfunction

   // Identity: reserved top half reads zero
   assign ident_word = {16'h0000,
                        IMP_CODE,
                        REV_CODE};

   // Timer strobes go only from move-to of the right number
   assign tally_we = i_mt_valid && (i_regnum == `SCRB_REG_CYCLE);
   assign match_we = i_mt_valid && (i_regnum == `SCRB_REG_MATCH);

   // Watch compares against software addresses
   assign instr_watch_address_hit = i_ifetch_valid &&
                       (i_ifetch_addr == regs_ff[`SCRB_REG_INSTR_WATCH_ADDRESS]);
   assign data_watch_address_hit = i_daccess_valid &&
                       (i_daccess_addr == regs_ff[`SCRB_REG_DATA_WATCH_ADDRESS]);

   // Read select: decode chain, unmapped gives fixed value
   assign rd_mux =
      (i_regnum == `SCRB_REG_IDENT) ? ident_word :
      (i_regnum == `SCRB_REG_CYCLE) ?
         {8'h00, tally_val} :
      (i_regnum == `SCRB_REG_MATCH) ?
         {8'h00, match_val} :
      (is_rw(i_regnum) || is_ro(i_regnum)) ?
         regs_ff[i_regnum] : `SCRB_UNMAPPED_VAL;

   scrb_tally #(
      .W (`SCRB_TALLY_W)
   ) u_tally (
      .i_clk      (i_clk),
      .i_sys_rst  (i_sys_rst),
      .i_tally_we (tally_we),
      .i_match_we (match_we),
      .i_wdata    (i_wdata[`SCRB_TALLY_W-1:0]),
      .o_tally    (tally_val),
      .o_match    (match_val),
      .o_hit      (tally_hit)
   );

   // Register array; hardware loads win for read-only words
   genvar gi;
   generate
      for (gi = 0; gi < 32; gi++) begin : g_reg
         localparam scrb_regnum_t N = scrb_regnum_t'(gi);
         if (N == `SCRB_REG_FAULT_ADDR) begin : g_fault
            always_ff @(posedge i_clk or posedge i_sys_rst) begin
               if (i_sys_rst) begin
                  regs_ff[gi] <= `SCRB_ZERO32;
               end else if (i_fault_valid) begin
                  regs_ff[gi] <= i_fault_addr;
               end
            end
         end else if (N == `SCRB_REG_CACHE_ERR) begin : g_cerr
            always_ff @(posedge i_clk or posedge i_sys_rst) begin
               if (i_sys_rst) begin
                  regs_ff[gi] <= `SCRB_ZERO32;
               end else if (i_cache_err_valid) begin
                  regs_ff[gi] <= i_cache_err_info;
               end
            end
         end else if (is_rw(N)) begin : g_rw
            always_ff @(posedge i_clk or posedge i_sys_rst) begin
               if (i_sys_rst) begin
                  regs_ff[gi] <= `SCRB_ZERO32;
               end else if (i_mt_valid && i_regnum == N) begin
                  regs_ff[gi] <= i_wdata;
               end
            end
         end else begin : g_none
            // Unimplemented slots stay constant
            assign regs_ff[gi] = `SCRB_ZERO32;
         end
      end
   endgenerate

   // Outputs, all registered
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_rdata              <= `SCRB_ZERO32;
         o_rvalid             <= 1'b0;
         o_timer_hit          <= 1'b0;
         o_watch_exc          <= 1'b0;
         o_mode_flags         <= `SCRB_ZERO32;
         o_bus_signal_setup   <= `SCRB_ZERO32;
         o_region_width_flags <= `SCRB_ZERO32;
         o_cpu_setup          <= `SCRB_ZERO32;
      end else begin
         o_rdata              <= i_mf_valid ? rd_mux : o_rdata;
         o_rvalid             <= i_mf_valid;
         o_timer_hit          <= tally_hit;
         o_watch_exc          <= instr_watch_address_hit || data_watch_address_hit;
         o_mode_flags         <= regs_ff[`SCRB_REG_MODE];
         o_bus_signal_setup   <= regs_ff[`SCRB_REG_BUS_SETUP];
         o_region_width_flags <= regs_ff[`SCRB_REG_REGION_WIDTH];
         o_cpu_setup          <= regs_ff[`SCRB_REG_CPU_SETUP];
      end
   end

   // Checks
   a_ident_read: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_mf_valid && i_regnum == `SCRB_REG_IDENT) |=>
      o_rdata == {16'h0000, IMP_CODE, REV_CODE})
      else $error("identity read wrong");
   a_ident_fixed: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_mt_valid && i_regnum == `SCRB_REG_IDENT) ##1
      (i_mf_valid && i_regnum == `SCRB_REG_IDENT) |=>
      o_rdata[15:0] == {IMP_CODE, REV_CODE})
      else $error("identity changed by write");
   a_fault_load: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_fault_valid ##1 (i_mf_valid && !i_fault_valid &&
       i_regnum == `SCRB_REG_FAULT_ADDR)) |=>
      o_rdata == $past(i_fault_addr, 2))
      else $error("faulting address not held");
   a_mode_wr: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_mt_valid && i_regnum == `SCRB_REG_MODE) |=> ##1
      o_mode_flags == $past(i_wdata, 2))
      else $error("mode flags not written");
   a_region_wr: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_mt_valid && i_regnum == `SCRB_REG_REGION_WIDTH) |=> ##1
      o_region_width_flags == $past(i_wdata, 2))
      else $error("region width not written");
   a_tally_top: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_mf_valid && i_regnum == `SCRB_REG_CYCLE) |=>
      o_rdata[31:24] == 8'h00)
      else $error("tally upper bits not zero");
   a_unmapped_rd: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_mf_valid && i_regnum == 5'h01) |=>
      o_rdata == `SCRB_UNMAPPED_VAL)
      else $error("unmapped read wrong");
   a_watch_exc: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_daccess_valid && !(i_mt_valid && i_regnum == `SCRB_REG_DATA_WATCH_ADDRESS)
       && i_daccess_addr == regs_ff[`SCRB_REG_DATA_WATCH_ADDRESS]) |=> o_watch_exc)
      else $error("watch exception missed");
   a_rdata_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !i_mf_valid |=> $stable(o_rdata))
      else $error("read data changed without a read");
   c_mode_read: cover property (@(posedge i_clk)
      i_mt_valid && i_regnum == `SCRB_REG_MODE ##1
      i_mf_valid && i_regnum == `SCRB_REG_MODE);
   c_watch: cover property (@(posedge i_clk) o_watch_exc);
   c_timer: cover property (@(posedge i_clk) o_timer_hit);
endmodule

/* verification/scrb_pipe_model.sv */
`timescale 1ns/1ps
// Pipeline side of the bank: one move at a time, optional stall first
module scrb_pipe_model
   import scrb_pkg::*;
(
   input  wire logic         i_clk,
   input  wire logic         i_rvalid,
   input  wire scrb_word_t   i_rdata,
   output logic              o_mt_valid,
   output logic              o_mf_valid,
   output scrb_regnum_t      o_regnum,
   output scrb_word_t        o_wdata
);
   initial begin
      o_mt_valid = 1'b0;
      o_mf_valid = 1'b0;
      o_regnum   = 5'h00;
      o_wdata    = 32'hA5A5_5A5A;
   end
   // Strobe for one cycle; fields scrambled when idle so stale data
   // never passes for a request
   task automatic issue(input logic wr, input scrb_regnum_t num,
                        input scrb_word_t d, input int gap);
      repeat (gap) @(posedge i_clk);
      @(posedge i_clk);
      #1;
      o_regnum = num;
      o_wdata  = d;
      if (wr) o_mt_valid = 1'b1;
      else o_mf_valid = 1'b1;
      @(posedge i_clk);
      #1;
      o_mt_valid = 1'b0;
      o_mf_valid = 1'b0;
      o_regnum   = ~o_regnum;
      o_wdata    = ~o_wdata;
   endtask
   task automatic move_to(input scrb_regnum_t num, input scrb_word_t d,
                          input int gap);
      issue(1'b1, num, d, gap);
   endtask
   // Write then read of one number in back-to-back cycles; the read
   // must see the value written just before it
   task automatic write_read(input scrb_regnum_t num, input scrb_word_t wd,
                             output scrb_word_t d);
      @(posedge i_clk);
      #1;
      o_regnum   = num;
      o_wdata    = wd;
      o_mt_valid = 1'b1;
      @(posedge i_clk);
      #1;
      o_mt_valid = 1'b0;
      o_mf_valid = 1'b1;
      @(posedge i_clk);
      #1;
      o_mf_valid = 1'b0;
      o_regnum   = ~o_regnum;
      o_wdata    = ~o_wdata;
      d = i_rdata;
   endtask
   // Answer is taken from the edge right after the request edge
   task automatic move_from(input scrb_regnum_t num, input int gap,
                            output scrb_word_t d, output logic ok);
      issue(1'b0, num, ~o_wdata, gap);
      d  = i_rdata;
      ok = (i_rvalid === 1'b1);
   endtask
endmodule

/* verification/system_control_register_bank_tb.sv */
`timescale 1ns/1ps
`include "scrb_map.svh"
module system_control_register_bank_tb;
   import scrb_pkg::*;
   localparam logic [7:0] IMP = 8'hC3; // Arbitrary value
   localparam logic [7:0] REV = 8'h4E; // Arbitrary value
   logic       clk, rst, mt, mf, hit, wexc, rvalid;
   logic       fv, iv, dv, cv;
   scrb_regnum_t num;
   scrb_word_t wdata, fa, ia, da, ci, rdata, mode, bus, reg_w, cpu;
   scrb_word_t d, v, m, mem [32];
   int         n_fail, num_checks, k;
   scrb_regnum_t rw_tab [16] = '{`SCRB_REG_BUS_SETUP, `SCRB_REG_PTE_PTR,
      `SCRB_REG_REGION_WIDTH, `SCRB_REG_MODE, `SCRB_REG_REASON,
      `SCRB_REG_EXC_PC, `SCRB_REG_CPU_SETUP, `SCRB_REG_INSTR_WATCH_ADDRESS,
      `SCRB_REG_DATA_WATCH_ADDRESS, `SCRB_REG_PTE_WIDE, `SCRB_REG_IMPR_PC,
      `SCRB_REG_DBG_PC, `SCRB_REG_DBG_CTRL, `SCRB_REG_ECC,
      `SCRB_REG_TAG_LOW, `SCRB_REG_ERR_PC};
   scrb_regnum_t un_tab [6] = '{5'h00, 5'h01, 5'h03, 5'h11, 5'h19, 5'h1F};

   scrb_pipe_model pipe (.i_clk(clk), .i_rvalid(rvalid), .i_rdata(rdata),
      .o_mt_valid(mt), .o_mf_valid(mf), .o_regnum(num), .o_wdata(wdata));
   scrb_top #(.IMP_CODE(IMP), .REV_CODE(REV)) uut (.i_clk(clk),
      .i_sys_rst(rst), .i_mt_valid(mt), .i_mf_valid(mf), .i_regnum(num),
      .i_wdata(wdata), .i_fault_valid(fv), .i_fault_addr(fa),
      .i_ifetch_valid(iv), .i_ifetch_addr(ia), .i_daccess_valid(dv),
      .i_daccess_addr(da), .i_cache_err_valid(cv), .i_cache_err_info(ci),
      .o_rdata(rdata), .o_rvalid(rvalid), .o_timer_hit(hit),
      .o_watch_exc(wexc), .o_mode_flags(mode), .o_bus_signal_setup(bus),
      .o_region_width_flags(reg_w), .o_cpu_setup(cpu));

   // Free-running 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Narrow registers only keep their low 24 bits
   function automatic scrb_word_t exp_rw(scrb_regnum_t n, scrb_word_t x);
      if (n == `SCRB_REG_CYCLE || n == `SCRB_REG_MATCH)
         return x & 32'h00FF_FFFF;
      return x;
   endfunction
   task automatic chk(input scrb_word_t got, input scrb_word_t exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rd(input scrb_regnum_t n, input int g);
      logic ok;
      pipe.move_from(n, g, d, ok);
      chk({31'h0, ok}, 32'h1);
   endtask
   task automatic close_out();
      $display("checks=%0d failures=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // One observed access, then the exception expected a cycle later
   task automatic watch_try(input logic data, input scrb_word_t a,
                            input logic exp);
      @(posedge clk);
      #1;
      if (data) {dv, da} = {1'b1, a};
      else {iv, ia} = {1'b1, a};
      @(posedge clk);
      #1;
      {iv, dv, ia, da} = {2'b00, ~a, ~a};
      chk({31'h0, wexc}, {31'h0, exp});
   endtask
   // Hang guard
   initial begin
      #200000;
      n_fail++;
      close_out();
   end
   initial begin
      {rst, fv, iv, dv, cv} = 5'b10000;
      {fa, ia, da, ci} = {4{32'h0F0F_0F0F}};
      v = $urandom(3510);
      repeat (12) @(posedge clk);
      #1;
      rst = 1'b0;
      rd(`SCRB_REG_IDENT, 0);
      chk(d, {16'h0000, IMP, REV});
      pipe.move_to(`SCRB_REG_IDENT, {16'h0000, 16'($urandom())}, 0);
      rd(`SCRB_REG_IDENT, 0);
      chk(d, {16'h0000, IMP, REV});
      pipe.write_read(`SCRB_REG_IDENT, {16'h0000, 16'($urandom())}, d);
      chk(d, {16'h0000, IMP, REV});
      // Back-to-back write and read of the mode flags
      v = $urandom();
      pipe.write_read(`SCRB_REG_MODE, v, d);
      chk(d, v);
      foreach (rw_tab[i]) begin
         mem[rw_tab[i]] = $urandom();
         pipe.move_to(rw_tab[i], mem[rw_tab[i]], $urandom_range(0, 2));
         rd(rw_tab[i], $urandom_range(0, 2));
         chk(d, mem[rw_tab[i]]);
      end
      chk(mode, mem[`SCRB_REG_MODE]);
      chk(bus, mem[`SCRB_REG_BUS_SETUP]);
      chk(reg_w, mem[`SCRB_REG_REGION_WIDTH]);
      chk(cpu, mem[`SCRB_REG_CPU_SETUP]);
      foreach (un_tab[i]) begin
         pipe.move_to(un_tab[i], $urandom(), 0);
         rd(un_tab[i], 1);
         chk(d, 32'h0000_0000);
      end
      // Event loads, fault address read back in the very next cycle, then writes that
      // must not land
      v = $urandom();
      @(posedge clk);
      #1;
      {fv, fa, cv, ci} = {1'b1, v, 1'b1, ~v};
      fork
         rd(`SCRB_REG_FAULT_ADDR, 0);
         begin
            @(posedge clk);
            #1;
            {fv, cv} = 2'b00;
         end
      join
      chk(d, v);
      pipe.move_to(`SCRB_REG_FAULT_ADDR, v ^ 32'h1, 0);
      pipe.move_to(`SCRB_REG_CACHE_ERR, v, 0);
      rd(`SCRB_REG_FAULT_ADDR, 0);
      chk(d, v);
      rd(`SCRB_REG_CACHE_ERR, 0);
      chk(d, ~v);
      // Tally readback and match wrap
      v = $urandom();
      pipe.move_to(`SCRB_REG_CYCLE, v, 0);
      rd(`SCRB_REG_CYCLE, 0);
      chk(d, exp_rw(`SCRB_REG_CYCLE, v + 32'h1));
      m = {8'hAB, 24'($urandom_range(100, 24'hFFFF00))};
      pipe.move_to(`SCRB_REG_MATCH, m, 0);
      rd(`SCRB_REG_MATCH, 0);
      chk(d, exp_rw(`SCRB_REG_MATCH, m));
      pipe.move_to(`SCRB_REG_CYCLE, m - 32'h5, 0);
      k = 0;
      while (k < 20 && hit !== 1'b1) begin
         @(posedge clk);
         #1;
         k++;
      end
      chk(scrb_word_t'(k), 32'h7);
      @(posedge clk);
      #1;
      chk({31'h0, hit}, 32'h0);
      // Watch: miss, then hit, on both paths
      v = $urandom();
      pipe.move_to(`SCRB_REG_INSTR_WATCH_ADDRESS, v, 0);
      pipe.move_to(`SCRB_REG_DATA_WATCH_ADDRESS, ~v, 0);
      watch_try(1'b0, v ^ 32'h4, 1'b0);
      watch_try(1'b0, v, 1'b1);
      watch_try(1'b1, v, 1'b0);
      watch_try(1'b1, ~v, 1'b1);
      // Mid-run reset: copies and read data clear, match back to all ones
      @(posedge clk);
      #1;
      rst = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk(mode, 32'h0000_0000);
      chk(rdata, 32'h0000_0000);
      rst = 1'b0;
      rd(`SCRB_REG_MATCH, 0);
      chk(d, 32'h00FF_FFFF);
      rd(`SCRB_REG_MODE, 0);
      chk(d, 32'h0000_0000);
      close_out();
   end
endmodule
